/* File: core/smsp_pkg.sv */
// Constants shared by the serial peripheral port core and its testbench.
// Assumes an 8-bit register port and one 40 MHz clock.

package smsp_pkg;

   // -----------------------------------------------------------------
   // Register offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] ADR_CTRL = 8'hc3;    // Control
   localparam logic [7:0] ADR_STAT = 8'hc4;    // Status flags
   localparam logic [7:0] ADR_DATA = 8'hc5;    // Data buffer

   // -----------------------------------------------------------------
   // Control fields
   // -----------------------------------------------------------------
   localparam int CB_RATE2 = 7;                // Rate select, bit 2
   localparam int CB_EN    = 6;                // Unit enable
   localparam int CB_MASTER_SELECT_BIT  = 4;                // Master select
   localparam int CB_CPOL  = 3;                // Clock idle level
   localparam int CB_CPHA  = 2;                // Clock phase
   localparam int CB_RATE1 = 1;                // Rate select, bit 1
   localparam int CB_RATE0 = 0;                // Rate select, bit 0
   localparam logic [7:0] CTRL_RESET = 8'h14;  // Control after reset
   localparam logic [7:0] CTRL_WMASK = 8'hdf;  // Bit 5 is unused

   // -----------------------------------------------------------------
   // Status fields
   // -----------------------------------------------------------------
   localparam int SB_TC    = 7;                // Transfer complete
   localparam int SB_WRITE_COLLISION_FLAG  = 6;                // Write collision
   localparam int SB_SELECT_RELEASE_ERROR_FLAG = 5;                // Select release error
   localparam int SB_MODE_FAULT_FLAG  = 4;                // Mode fault
   localparam logic       FLAG_RESET = 1'b0;   // Flags after reset
   localparam logic [3:0] STAT_RSVD  = 4'h0;   // Reserved bits read

   // -----------------------------------------------------------------
   // Timing and sizes
   // -----------------------------------------------------------------
   localparam logic [4:0] EDGES_PER_BYTE = 5'h10;  // 8 bits, 2 edges
   localparam logic [2:0] RATE_INVALID   = 3'h7;   // Forbidden code
   localparam logic [2:0] RATE_SLOWEST   = 3'h6;   // Divide by 128
   localparam logic [6:0] HALF_UNIT      = 7'h01;  // Half period base

   // Transfer state
   typedef enum logic {ST_IDLE, ST_XFER} smsp_state_e;

endpackage

/* File: core/smsp_sync.sv */
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous inputs and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none

module smsp_sync #(
   parameter int         W    = 1,              // Number of lines
   parameter logic [W-1:0] INIT = '0             // Value held in reset
) (
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);

   logic [W-1:0] s1;                            // Metastable stage
   logic [W-1:0] s2;                            // Second stage
   logic [W-1:0] s3;                            // Third stage
   logic [W-1:0] next_q;                        // Filtered value

   // -----------------------------------------------------------------
   // Filter: a change counts once stages two and three agree
   // -----------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < W; i++) begin
         next_q[i] = (s2[i] == s3[i]) ? s3[i] : q[i];
      end
   end

   // Stage one feeds only stage two, to keep metastability contained
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s1 <= INIT;
         s2 <= INIT;
         s3 <= INIT;
         q  <= INIT;
      end else begin
         s1 <= d;
         s2 <= s1;
         s3 <= s2;
         q  <= next_q;
      end
   end

endmodule

`default_nettype wire

/* File: core/smsp_core.sv */
// Serial peripheral port: master or slave byte exchanger with registers.
// Assumes a one-cycle register port on MCLK and pins resolved outside
// from each output and its enable.
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module smsp_core (
   input  wire logic       MCLK,
   input  wire logic       RST_B,
   input  wire logic [7:0] ADDR,
   input  wire logic [7:0] WDATA,
   input  wire logic       WR,
   input  wire logic       RD,
   output var  logic [7:0] RDATA,
   input  wire logic       SCK_I,
   output var  logic       SCK_O,
   output var  logic       SCK_OE,
   input  wire logic       MOSI_I,
   output var  logic       MOSI_O,
   output var  logic       MOSI_OE,
   input  wire logic       MISO_I,
   output var  logic       MISO_O,
   output var  logic       MISO_OE,
   input  wire logic       SS_B
);

   // -----------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------
   logic [7:0]              ctrl;          // Control register
   logic                    tc;            // Transfer complete flag
   logic                    write_collision_flag;          // Write collision flag
   logic                    select_release_error_flag;         // Select release error flag
   logic                    mode_fault_flag;          // Mode fault flag
   logic                    armed;         // Status read seen
   logic [7:0]              sr;            // Shift register
   logic [7:0]              rx_buf;        // Receive buffer
   logic                    out_bit;       // Bit on the data output
   logic [4:0]              cnt;           // Clock edges in this byte
   logic [6:0]              div_cnt;       // Master half-period count
   logic                    sck_prev;      // Last synchronised clock
   smsp_pkg::smsp_state_e   st;            // Transfer state

   logic [7:0]              next_ctrl;
   logic                    next_tc;
   logic                    next_write_collision_flag;
   logic                    next_select_release_error_flag;
   logic                    next_mode_fault_flag;
   logic                    next_armed;
   logic [7:0]              next_sr;
   logic [7:0]              next_rx_buf;
   logic                    next_out_bit;
   logic [4:0]              next_cnt;
   logic [6:0]              next_div_cnt;
   smsp_pkg::smsp_state_e   next_st;
   logic [7:0]              next_rdata;
   logic                    next_sck_o;
   logic                    next_sck_oe;
   logic                    next_mosi_oe;
   logic                    next_miso_oe;

   logic                    en;            // Unit enabled
   logic                    master_select_bit;          // Master role
   logic                    cpol;          // Clock idle level
   logic                    cpha;          // Sample on second edge
   logic [2:0]              rate;          // Effective rate code
   logic [6:0]              half;          // MCLK cycles per half bit
   logic                    sck_s;         // Filtered clock pin
   logic                    mosi_s;        // Filtered master-out pin
   logic                    miso_s;        // Filtered master-in pin
   logic                    ss_s;          // Filtered select, low active
   logic                    edge_ev;       // A bit clock edge now
   logic                    is_lead;       // That edge leaves idle level
   logic                    din;           // Incoming serial bit
   logic                    wr_data;       // Write to data register
   logic                    data_acc;      // Any data register access

   // -----------------------------------------------------------------
   // Pin synchronisers; select idles high, the rest low
   // -----------------------------------------------------------------
   smsp_sync #(
      .W    (4),
      .INIT (4'h1)
   ) u_sync (
      .clk   (MCLK),
      .rst_b (RST_B),
      .d     ({SCK_I, MOSI_I, MISO_I, SS_B}),
      .q     ({sck_s, mosi_s, miso_s, ss_s})
   );

   // -----------------------------------------------------------------
   // Decoded control fields
   // -----------------------------------------------------------------
   assign en       = ctrl[smsp_pkg::CB_EN];
   assign master_select_bit     = ctrl[smsp_pkg::CB_MASTER_SELECT_BIT];
   assign cpol     = ctrl[smsp_pkg::CB_CPOL];
   assign cpha     = ctrl[smsp_pkg::CB_CPHA];
   assign wr_data  = WR && (ADDR == smsp_pkg::ADR_DATA);
   assign data_acc = (WR || RD) && (ADDR == smsp_pkg::ADR_DATA);

   // Invalid code 111 falls back to the slowest rate, never faster
   assign rate = ({ctrl[smsp_pkg::CB_RATE2], ctrl[smsp_pkg::CB_RATE1],
                   ctrl[smsp_pkg::CB_RATE0]} == smsp_pkg::RATE_INVALID)
                 ? smsp_pkg::RATE_SLOWEST
                 : {ctrl[smsp_pkg::CB_RATE2], ctrl[smsp_pkg::CB_RATE1],
                    ctrl[smsp_pkg::CB_RATE0]};
   assign half = smsp_pkg::HALF_UNIT << rate;

   // -----------------------------------------------------------------
   // Next-state logic for registers, flags and the shifter
   // -----------------------------------------------------------------
   always_comb begin
      next_ctrl    = ctrl;
      next_tc      = tc;
      next_write_collision_flag    = write_collision_flag;
      next_select_release_error_flag   = select_release_error_flag;
      next_mode_fault_flag    = mode_fault_flag;
      next_armed   = armed;
      next_sr      = sr;
      next_rx_buf  = rx_buf;
      next_out_bit = out_bit;
      next_cnt     = cnt;
      next_div_cnt = div_cnt;
      next_st      = st;
      next_sck_o   = SCK_O;
      edge_ev      = 1'b0;
      is_lead      = 1'b0;
      din          = master_select_bit ? miso_s : mosi_s;

      // Control write; role is chosen here before exchanges
      if (WR && (ADDR == smsp_pkg::ADR_CTRL)) begin
         next_ctrl = WDATA & smsp_pkg::CTRL_WMASK;
      end

      // Clearing sequence first so that hardware sets below win
      if (RD && (ADDR == smsp_pkg::ADR_STAT)) begin
         next_armed = 1'b1;
      end
      if (data_acc && armed) begin
         next_tc    = 1'b0;
         next_write_collision_flag  = 1'b0;
         next_mode_fault_flag  = 1'b0;
         next_armed = 1'b0;
      end

      // Data write: direct load while idle, overflow while busy
      if (wr_data) begin
         if (st == smsp_pkg::ST_XFER) begin
            next_write_collision_flag = 1'b1;
         end else begin
            next_sr = WDATA;
            if (en && master_select_bit) begin
               next_st      = smsp_pkg::ST_XFER;
               next_cnt     = '0;
               next_div_cnt = '0;
               next_tc      = 1'b0;
               // Phase 0 presents the first bit before any edge
               if (!cpha) begin
                  next_out_bit = WDATA[7];
               end
            end
         end
      end

      // Slave begins when selected; first bit shown for phase 0
      // Completion flag is kept until the first clock edge, so a select
      // held low past the end of a byte does not hide the finished one
      if (en && !master_select_bit && !ss_s && (st == smsp_pkg::ST_IDLE)) begin
         next_st  = smsp_pkg::ST_XFER;
         next_cnt = '0;
         if (!cpha) begin
            next_out_bit = sr[7];
         end
      end

      // Bit clock edges: made by the divider or seen on the pin
      if (st == smsp_pkg::ST_XFER) begin
         if (cnt == smsp_pkg::EDGES_PER_BYTE) begin
            // Byte finished; only the receive buffer is read back
            next_rx_buf = sr;
            next_tc     = 1'b1;
            next_st     = smsp_pkg::ST_IDLE;
            next_cnt    = '0;
         end else if (master_select_bit) begin
            if (div_cnt == half - smsp_pkg::HALF_UNIT) begin
               next_div_cnt = '0;
               next_sck_o   = ~SCK_O;
               edge_ev      = 1'b1;
               is_lead      = (SCK_O == cpol);
            end else begin
               next_div_cnt = div_cnt + smsp_pkg::HALF_UNIT;
            end
         end else if (ss_s) begin
            // Select dropped before the byte was complete; no edge yet
            // means no byte had begun, so that is no error
            if (cnt != 5'h00) begin
               next_select_release_error_flag = 1'b1;
            end
            next_st    = smsp_pkg::ST_IDLE;
            next_cnt   = '0;
         end else if (sck_s != sck_prev) begin
            edge_ev = 1'b1;
            is_lead = (sck_prev == cpol);
         end
      end

      // Sample on one edge of each bit, shift out on the other
      if (edge_ev) begin
         next_cnt = cnt + 5'h01;
         // First edge marks the exchange as in progress
         if (cnt == 5'h00) begin
            next_tc = 1'b0;
         end
         if (is_lead != cpha) begin
            next_sr = {sr[6:0], din};
         end else begin
            next_out_bit = sr[7];
         end
      end

      // Master sees select driven low by another party
      if (en && master_select_bit && !ss_s) begin
         next_mode_fault_flag = 1'b1;
         next_st   = smsp_pkg::ST_IDLE;
         next_cnt  = '0;
      end

      // Clock rests at its idle level whenever no byte is moving
      if (next_st == smsp_pkg::ST_IDLE) begin
         next_sck_o = cpol;
      end

      // Disable acts at once, even mid-byte
      if (!en) begin
         next_st    = smsp_pkg::ST_IDLE;
         next_cnt   = '0;
         next_select_release_error_flag = 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Pin enables and read data
   // -----------------------------------------------------------------
   always_comb begin
      next_sck_oe  = en && master_select_bit;
      next_mosi_oe = en && master_select_bit;
      // Slave output stays off unless selected
      next_miso_oe = en && !master_select_bit && !ss_s;
      next_rdata   = 8'h00;
      if (RD) begin
         unique case (ADDR)
            smsp_pkg::ADR_CTRL: next_rdata = ctrl;
            smsp_pkg::ADR_STAT: next_rdata = {tc, write_collision_flag, select_release_error_flag, mode_fault_flag,
                                              smsp_pkg::STAT_RSVD};
            smsp_pkg::ADR_DATA: next_rdata = rx_buf;
            default:            next_rdata = 8'h00;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // State registers
   // -----------------------------------------------------------------
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         ctrl     <= smsp_pkg::CTRL_RESET;
         tc       <= smsp_pkg::FLAG_RESET;
         write_collision_flag     <= smsp_pkg::FLAG_RESET;
         select_release_error_flag    <= smsp_pkg::FLAG_RESET;
         mode_fault_flag     <= smsp_pkg::FLAG_RESET;
         armed    <= 1'b0;
         sr       <= 8'h00;
         rx_buf   <= 8'h00;
         out_bit  <= 1'b0;
         cnt      <= '0;
         div_cnt  <= '0;
         sck_prev <= 1'b0;
         st       <= smsp_pkg::ST_IDLE;
         RDATA    <= 8'h00;
         SCK_O    <= 1'b0;
         SCK_OE   <= 1'b0;
         MOSI_OE  <= 1'b0;
         MISO_OE  <= 1'b0;
      end else begin
         ctrl     <= next_ctrl;
         tc       <= next_tc;
         write_collision_flag     <= next_write_collision_flag;
         select_release_error_flag    <= next_select_release_error_flag;
         mode_fault_flag     <= next_mode_fault_flag;
         armed    <= next_armed;
         sr       <= next_sr;
         rx_buf   <= next_rx_buf;
         out_bit  <= next_out_bit;
         cnt      <= next_cnt;
         div_cnt  <= next_div_cnt;
         sck_prev <= sck_s;
         st       <= next_st;
         RDATA    <= next_rdata;
         SCK_O    <= next_sck_o;
         SCK_OE   <= next_sck_oe;
         MOSI_OE  <= next_mosi_oe;
         MISO_OE  <= next_miso_oe;
      end
   end

   // One flip-flop feeds both data outputs; only one is ever enabled
   assign MOSI_O = out_bit;
   assign MISO_O = out_bit;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!RST_B);

   chk_role_drive: assert property (
      (en && master_select_bit) |=> (SCK_OE && MOSI_OE && !MISO_OE))
      else $error("master role without clock drive");

   chk_slave_quiet: assert property (
      (!en || master_select_bit || ss_s) |=> !MISO_OE)
      else $error("slave output driven while unselected");

   chk_rate_half: assert property (
      (st == smsp_pkg::ST_XFER && master_select_bit && $stable(ctrl)
       && $changed(SCK_O) && $past(st) == smsp_pkg::ST_XFER)
      |-> ($past(div_cnt) == half - smsp_pkg::HALF_UNIT))
      else $error("bit clock toggled off the divider");

   chk_ctrl_reset: assert property (
      $rose(RST_B) |-> (ctrl == smsp_pkg::CTRL_RESET && !tc && !mode_fault_flag))
      else $error("wrong values after reset");

   chk_done_flag: assert property (
      (st == smsp_pkg::ST_XFER && cnt == smsp_pkg::EDGES_PER_BYTE)
      |=> (tc && st == smsp_pkg::ST_IDLE && rx_buf == $past(sr)))
      else $error("finished byte not flagged");

   chk_busy_clear: assert property (
      (st == smsp_pkg::ST_XFER && cnt != 5'h00) |-> !tc)
      else $error("complete flag set during exchange");

   chk_overflow_write: assert property (
      (wr_data && st == smsp_pkg::ST_XFER) |=> write_collision_flag ##1 (write_collision_flag || !armed))
      else $error("overflow write not flagged");

   chk_select_error: assert property (
      (st == smsp_pkg::ST_XFER && en && !master_select_bit && ss_s && cnt != 5'h00
       && cnt != smsp_pkg::EDGES_PER_BYTE) |=> select_release_error_flag)
      else $error("early select release not flagged");

   chk_disable_stop: assert property (
      !en |=> (st == smsp_pkg::ST_IDLE && !select_release_error_flag))
      else $error("disabled unit still active");

   chk_direct_load: assert property (
      (wr_data && st == smsp_pkg::ST_IDLE) |=> (sr == $past(WDATA)))
      else $error("data write did not load shifter");

   chk_rx_read: assert property (
      (RD && ADDR == smsp_pkg::ADR_DATA) |=> (RDATA == $past(rx_buf)))
      else $error("data read not from receive buffer");

   chk_mode_fault: assert property (
      (en && master_select_bit && !ss_s) |=> (mode_fault_flag && st == smsp_pkg::ST_IDLE)[*2])
      else $error("mode fault not raised");

endmodule

`default_nettype wire

/* File: dv/smsp_far_end.sv */
// Far-side model of the serial link: a slave answering the core in
// master role, and a master driving the core in slave role.
// Assumes idle-low clock, sample on rising edge, paced by the core clock.
`timescale 1ns/1ps
`default_nettype none

module smsp_far_end (
   input  wire logic clk,      // Core clock, paces the master role
   input  wire logic sck,      // Resolved serial clock
   input  wire logic mosi,     // Resolved master-out line
   input  wire logic miso,     // Resolved master-in line
   output var  logic sck_d,    // Clock level while driving
   output var  logic sck_oe,   // High while acting as master
   output var  logic mosi_d,   // Master-out level while driving
   output var  logic miso_d,   // Slave answer bit
   output var  logic miso_oe,  // High while the slave answers
   output var  logic ss_b      // Select towards the core, active low
);
   logic [7:0] tx;             // Slave shift-out byte
   logic [7:0] rx;             // Byte seen on master-out

   initial begin
      {sck_d, sck_oe, mosi_d, miso_oe, tx, rx} = '0;
      miso_d = 1'b1;
      ss_b   = 1'b1;
   end

   // ----------------------------------------------------------------
   // Slave role
   // ----------------------------------------------------------------
   // Sample on the rising edge; idle while driving the clock ourselves
   always @(posedge sck) begin
      if (!sck_oe) begin
         rx <= {rx[6:0], mosi};
      end
   end

   // Next bit leaves on the falling edge, so it is stable at the rise
   always @(negedge sck) begin
      if (miso_oe) begin
         tx     <= tx << 1;
         miso_d <= tx[6];
      end
   end

   task automatic load(input logic [7:0] b);
      tx      <= b;
      miso_d  <= b[7];           // First bit shown before any edge
      miso_oe <= 1'b1;
      rx      <= 8'h00;
   endtask

   // Released line floats to its pull-up in the bench
   task automatic drop();
      miso_oe <= 1'b0;
   endtask

   task automatic sel(input logic v);
      ss_b <= v;
   endtask

   // ----------------------------------------------------------------
   // Master role: 8 core cycles per half bit, slow enough for the
   // core's input synchronisers
   // ----------------------------------------------------------------
   task automatic xfer(input logic [7:0] b, input int nb,
                       output logic [7:0] r);
      logic [7:0] sh;
      sh = b;
      r  = 8'h00;
      ss_b   <= 1'b0;
      sck_oe <= 1'b1;
      mosi_d <= sh[7];
      repeat (8) @(posedge clk);
      for (int i = 0; i < nb; i++) begin
         sck_d <= 1'b1;
         repeat (8) @(posedge clk);
         r = {r[6:0], miso};
         sck_d <= 1'b0;
         sh = sh << 1;
         mosi_d <= sh[7];
         repeat (8) @(posedge clk);
      end
      ss_b   <= 1'b1;
      sck_oe <= 1'b0;
      mosi_d <= ~mosi_d;         // Undriven line must not look stable
   endtask
endmodule

`default_nettype wire

/* File: dv/tb.sv */
// Self-checking bench for the serial peripheral port core.
// Assumes the far-side model and a one-cycle register port.
`timescale 1ns/1ps
`default_nettype none

module tb;
   logic       mclk, rst_b, wr, rd;        // Clock, reset, strobes
   logic [7:0] addr, wdata, rdata;         // Register port
   logic       sck_o, sck_oe, mosi_o;      // Core pin drivers
   logic       mosi_oe, miso_o, miso_oe;
   logic       p_sck, p_sck_oe, p_mosi;    // Far-side pin drivers
   logic       p_miso, p_miso_oe, ss_b;
   logic       sck, mosi, miso;            // Resolved wires
   int         n_errors, checked;          // Verdict counters

   // Pull-down on the clock, pull-up on master-in
   assign sck  = sck_oe ? sck_o : (p_sck_oe ? p_sck : 1'b0);
   assign mosi = mosi_oe ? mosi_o : p_mosi;
   assign miso = miso_oe ? miso_o : (p_miso_oe ? p_miso : 1'b1);

   smsp_core smsp_core_inst (.MCLK(mclk), .RST_B(rst_b), .ADDR(addr),
      .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .SCK_I(sck),
      .SCK_O(sck_o), .SCK_OE(sck_oe), .MOSI_I(mosi), .MOSI_O(mosi_o),
      .MOSI_OE(mosi_oe), .MISO_I(miso), .MISO_O(miso_o),
      .MISO_OE(miso_oe), .SS_B(ss_b));

   smsp_far_end smsp_far_end_inst (.clk(mclk), .sck(sck), .mosi(mosi),
      .miso(miso), .sck_d(p_sck), .sck_oe(p_sck_oe), .mosi_d(p_mosi),
      .miso_d(p_miso), .miso_oe(p_miso_oe), .ss_b(ss_b));

   // ----------------------------------------------------------------
   // Clock and shared tasks
   // ----------------------------------------------------------------
   always #12.5 mclk = ~mclk;

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Strobe is dropped then one edge passes, so calls may follow
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
      @(posedge mclk);
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rc(input logic [7:0] a, input logic [7:0] exp);
      addr <= a;
      rd   <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      @(negedge mclk);
      chk(rdata, exp);
      @(posedge mclk);
   endtask

   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      // Idle accesses only; status is never written
      rc(smsp_pkg::ADR_CTRL, smsp_pkg::CTRL_RESET);
      rc(smsp_pkg::ADR_STAT, 8'h00);
      wr_reg(8'h00, 8'hff);                         // Unmapped, ignored
      rc(8'h00, 8'h00);
   endtask

   // Rate codes 0 to 6; idle level; abort by clearing the enable
   task automatic t_rate();
      logic [7:0] c;
      logic       s;
      int         n;
      for (int r = 0; r < 7; r++) begin
         c = {r[2], 3'b101, r[0], 1'b0, r[1:0]};
         wr_reg(smsp_pkg::ADR_CTRL, c);
         @(negedge mclk);
         chk(8'(sck_o), 8'(r[0]));
         @(posedge mclk);
         wr_reg(smsp_pkg::ADR_DATA, 8'h00);
         n = 0;
         @(negedge mclk);
         s = sck_o;
         while (sck_o === s && n < 300) begin
            @(negedge mclk);
            n++;
         end
         s = sck_o;
         n = 0;
         while (sck_o === s && n < 300) begin
            @(negedge mclk);
            n++;
         end
         chk(8'(n), 8'(1 << r));
         @(posedge mclk);
         wr_reg(smsp_pkg::ADR_CTRL, 8'h00);
         @(negedge mclk);
         chk(8'(sck_oe), 8'h00);
         @(posedge mclk);
      end
   endtask

   // Master byte with an overflow write in mid-exchange
   task automatic t_master();
      wr_reg(smsp_pkg::ADR_CTRL, 8'h53); // Idle, so rate may change
      smsp_far_end_inst.load(8'h3c);
      wr_reg(smsp_pkg::ADR_DATA, 8'ha5);
      repeat (20) @(posedge mclk);
      rc(smsp_pkg::ADR_STAT, 8'h00);
      wr_reg(smsp_pkg::ADR_DATA, 8'hff);
      repeat (130) @(posedge mclk);
      rc(smsp_pkg::ADR_STAT, 8'hc0);
      rc(smsp_pkg::ADR_DATA, 8'h3c);
      chk(smsp_far_end_inst.rx, 8'ha5);
      rc(smsp_pkg::ADR_STAT, 8'h00);
      smsp_far_end_inst.drop();
   endtask

   task automatic t_fault();
      smsp_far_end_inst.sel(1'b0);
      repeat (8) @(posedge mclk);
      rc(smsp_pkg::ADR_STAT, 8'h10);
      smsp_far_end_inst.sel(1'b1);
      repeat (8) @(posedge mclk);
      rc(smsp_pkg::ADR_DATA, 8'h3c);
      rc(smsp_pkg::ADR_STAT, 8'h00);
   endtask

   // Slave byte, then an early select release
   task automatic t_slave();
      logic [7:0] r;
      wr_reg(smsp_pkg::ADR_CTRL, 8'h40);
      wr_reg(smsp_pkg::ADR_DATA, 8'h96);
      repeat (6) @(posedge mclk);
      @(negedge mclk);
      chk(8'(miso_oe), 8'h00);
      @(posedge mclk);
      smsp_far_end_inst.xfer(8'h5a, 8, r);
      chk(r, 8'h96);
      repeat (8) @(posedge mclk);
      rc(smsp_pkg::ADR_STAT, 8'h80);
      rc(smsp_pkg::ADR_DATA, 8'h5a);
      smsp_far_end_inst.xfer(8'h00, 4, r);
      repeat (8) @(posedge mclk);
      rc(smsp_pkg::ADR_STAT, 8'h20);
      rc(smsp_pkg::ADR_DATA, 8'h5a);
      rc(smsp_pkg::ADR_STAT, 8'h20);
      wr_reg(smsp_pkg::ADR_CTRL, 8'h00);
      rc(smsp_pkg::ADR_STAT, 8'h00);
   endtask

   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      {mclk, rst_b, wr, rd, addr, wdata} = '0;
      n_errors = 0;
      checked  = 0;
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      t_reset();
      t_rate();
      t_master();
      t_fault();
      t_slave();
      finish_test();
   end

   // Whole run needs under a thousand cycles
   initial begin
      repeat (20000) @(posedge mclk);
      n_errors++;
      finish_test();
   end
endmodule

`default_nettype wire
